// *** inc/clock_gen_pkg.sv ***
// Constants, field layout and types for the clock generator control block
package clock_gen_pkg;

  // ----------------------------------------------------------------
  // Bus and clock rates
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int CLK_HZ = 40_000_000;
  localparam int SLOW_CLK_HZ = 32_768;
  localparam int SLOW_TICK_CYCLES = CLK_HZ / SLOW_CLK_HZ;
  localparam int RC_STARTUP_SLOW = 8;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_PERIPH_CLK_ENABLE = 32'h0FFF_FC10;
  localparam logic [ADDR_W-1:0] ADDR_PERIPH_CLK_DISABLE = 32'h0FFF_FC14;
  localparam logic [ADDR_W-1:0] ADDR_PERIPH_CLK_STATUS = 32'h0FFF_FC18;
  localparam logic [ADDR_W-1:0] ADDR_USB_PHY_PLL_CONFIG = 32'h0FFF_FC1C;
  localparam logic [ADDR_W-1:0] ADDR_MAIN_OSC_CONTROL = 32'h0FFF_FC20;
  localparam logic [ADDR_W-1:0] ADDR_MAIN_CLK_FREQ = 32'hFFFF_FC24;
  localparam logic [ADDR_W-1:0] ADDR_PLL_A_CONFIG = 32'hFFFF_FC28;
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_STATUS = 32'hFFFF_FC68;
  localparam logic [ADDR_W-1:0] ADDR_WRITE_PROTECT = 32'hFFFF_FCE4;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] PERIPH_IMPL_MASK = 32'hFFFF_FFFC;
  localparam logic [DATA_W-1:0] USB_PHY_RESET = 32'h1020_0000;
  localparam logic [DATA_W-1:0] MAIN_OSC_RESET = 32'h0000_0008;
  localparam logic [DATA_W-1:0] PLL_A_RESET = 32'h0000_3F00;
  localparam logic [7:0] WRITE_KEY_VALUE = 8'h37;
  localparam int STARTUP_SHIFT = 3;
  localparam logic [4:0] MEASURE_PERIODS = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int USB_PLL_ON_BIT = 16;
  localparam int USB_PLL_STARTUP_LSB = 20;
  localparam int USB_BIAS_ON_BIT = 24;
  localparam int USB_BIAS_STARTUP_LSB = 28;
  localparam int XT_ON_BIT = 0;
  localparam int XT_BYPASS_BIT = 1;
  localparam int RC_ON_BIT = 3;
  localparam int XT_STARTUP_LSB = 8;
  localparam int KEY_LSB = 16;
  localparam int KEY_BYTE = 2;
  localparam int SRC_SEL_BIT = 24;
  localparam int CFD_ON_BIT = 25;
  localparam int MEASURED_MAIN_COUNT_LSB = 0;
  localparam int MEAS_READY_BIT = 16;
  localparam int PLL_DIV_LSB = 0;
  localparam int PLL_COUNT_LSB = 8;
  localparam int PLL_RANGE_LSB = 14;
  localparam int PLL_MUL_LSB = 16;
  localparam int PLL_ONE_BIT = 29;
  localparam int ST_XT_STABLE_BIT = 0;
  localparam int ST_PLL_A_LOCKED_BIT = 1;
  localparam int ST_USB_PLL_LOCKED_BIT = 6;
  localparam int ST_RC_STABLE_BIT = 17;
  localparam int WP_ENABLE_BIT = 0;

  typedef enum logic {MEAS_IDLE, MEAS_RUN} meas_state_e;

endpackage

// *** rtl/clock_gen_osc_pll_control.sv ***
// Clock generator control: peripheral clocks, oscillators, PLLs, AXI4-Lite registers
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Disable-register ones stop peripheral clocks 2..31
// - Write protect enable blocks configuration writes
// - Status register shows running peripheral clocks
// - USB PLL locked after its start-up time
// - USB PLL start-up is count times eight
// - Bias on/off, start-up equals bias count
// - Oscillator write dropped without correct key
// - Crystal stable after crystal start-up time
// - Bypass makes crystal stable at once
// - Crystal and bypass off clears stable
// - RC stable after RC start-up time
// - Crystal start-up is field times eight
// - Source select: 0 RC, 1 crystal
// - Failure detector runs only when enabled
// - Count main ticks over sixteen slow periods
// - Divider field 0 off, 1 bypass, else divide
// - PLL A locked after programmed slow cycles
// - Multiplier 0 off, else times value plus one
module clock_gen_osc_pll_control
  import clock_gen_pkg::*;
#(
  parameter int SLOW_DIV = SLOW_TICK_CYCLES,
  parameter int RC_STARTUP = RC_STARTUP_SLOW
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Main clock edge marker for the frequency meter
  input wire logic i_main_clk_tick,
  // AXI4-Lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  // AXI4-Lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic [DATA_W/8-1:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read address
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  // AXI4-Lite read data
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  // Peripheral clock gates
  output logic [DATA_W-1:0] o_peripheral_clock_bit,
  // USB PHY PLL and bias
  output logic o_usb_phy_pll_on,
  output logic o_usb_phy_pll_locked,
  output logic o_usb_phy_bias_on,
  output logic o_usb_phy_bias_ready,
  // Main oscillators
  output logic o_crystal_osc_on,
  output logic o_crystal_osc_bypass,
  output logic o_crystal_osc_stable,
  output logic o_rc_osc_on,
  output logic o_rc_osc_stable,
  output logic o_main_source_select,
  output logic o_clock_fail_detect_on,
  // PLL A
  output logic [7:0] o_pll_a_divider,
  output logic [7:0] o_pll_a_multiplier,
  output logic [1:0] o_pll_a_freq_range,
  output logic o_pll_a_locked
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int SLOW_W = $clog2(SLOW_DIV + 1);

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] awaddr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W/8-1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] periph_en;
    logic wp_en;
    logic upll_on;
    logic [3:0] upll_startup;
    logic bias_on;
    logic [3:0] bias_startup;
    logic xt_on;
    logic xt_by;
    logic rc_on;
    logic [7:0] xt_startup;
    logic src_sel;
    logic cfd_on;
    logic [7:0] pll_div;
    logic [7:0] pll_mul;
    logic [5:0] pll_count;
    logic [1:0] pll_range;
    logic pll_one;
    logic [SLOW_W-1:0] slow_div;
    logic slow_tick;
    logic [10:0] xt_left;
    logic xt_stable;
    logic [7:0] rc_left;
    logic rc_stable;
    logic [6:0] upll_left;
    logic upll_locked;
    logic [3:0] bias_left;
    logic bias_ready;
    logic [5:0] pll_left;
    logic pll_locked;
    meas_state_e meas_state;
    logic [4:0] meas_win;
    logic [15:0] meas_acc;
    logic [15:0] measured_main_count;
    logic measured_main_count_rdy;
  } state_s;

  state_s q_ff;
  state_s nxt_q;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    case (addr)
      ADDR_PERIPH_CLK_ENABLE, ADDR_PERIPH_CLK_DISABLE, ADDR_PERIPH_CLK_STATUS,
      ADDR_USB_PHY_PLL_CONFIG, ADDR_MAIN_OSC_CONTROL, ADDR_MAIN_CLK_FREQ,
      ADDR_PLL_A_CONFIG, ADDR_CLOCK_STATUS, ADDR_WRITE_PROTECT: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [DATA_W-1:0] byte_mask(input logic [DATA_W/8-1:0] strb);
    byte_mask = '0;
    for (int i = 0; i < DATA_W / 8; i++) begin
      byte_mask[i*8 +: 8] = {8{strb[i]}};
    end
  endfunction

  function automatic logic [DATA_W-1:0] read_word(input state_s s,
                                                  input logic [ADDR_W-1:0] addr);
    read_word = '0;
    case (addr)
      ADDR_PERIPH_CLK_STATUS: read_word = s.periph_en;
      ADDR_USB_PHY_PLL_CONFIG: begin
        read_word[USB_PLL_ON_BIT] = s.upll_on;
        read_word[USB_PLL_STARTUP_LSB +: 4] = s.upll_startup;
        read_word[USB_BIAS_ON_BIT] = s.bias_on;
        read_word[USB_BIAS_STARTUP_LSB +: 4] = s.bias_startup;
      end
      ADDR_MAIN_OSC_CONTROL: begin
        read_word[XT_ON_BIT] = s.xt_on;
        read_word[XT_BYPASS_BIT] = s.xt_by;
        read_word[RC_ON_BIT] = s.rc_on;
        read_word[XT_STARTUP_LSB +: 8] = s.xt_startup;
        read_word[SRC_SEL_BIT] = s.src_sel;
        read_word[CFD_ON_BIT] = s.cfd_on;
      end
      ADDR_MAIN_CLK_FREQ: begin
        read_word[MEASURED_MAIN_COUNT_LSB +: 16] = s.measured_main_count;
        read_word[MEAS_READY_BIT] = s.measured_main_count_rdy;
      end
      ADDR_PLL_A_CONFIG: begin
        read_word[PLL_DIV_LSB +: 8] = s.pll_div;
        read_word[PLL_COUNT_LSB +: 6] = s.pll_count;
        read_word[PLL_RANGE_LSB +: 2] = s.pll_range;
        read_word[PLL_MUL_LSB +: 8] = s.pll_mul;
        read_word[PLL_ONE_BIT] = s.pll_one;
      end
      ADDR_CLOCK_STATUS: begin
        read_word[ST_XT_STABLE_BIT] = s.xt_stable;
        read_word[ST_PLL_A_LOCKED_BIT] = s.pll_locked;
        read_word[ST_USB_PLL_LOCKED_BIT] = s.upll_locked;
        read_word[ST_RC_STABLE_BIT] = s.rc_stable;
      end
      ADDR_WRITE_PROTECT: read_word[WP_ENABLE_BIT] = s.wp_en;
      default: read_word = '0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic do_write;
  logic pll_restart;
  logic osc_ok;
  logic [DATA_W-1:0] wmask;
  logic [DATA_W-1:0] merged;
  logic [DATA_W-1:0] wbits;
  logic [15:0] acc_inc;

  always_comb begin
    nxt_q = q_ff;
    pll_restart = 1'b0;
    wmask = byte_mask(q_ff.wstrb);
    merged = (read_word(q_ff, q_ff.awaddr) & ~wmask) | (q_ff.wdata & wmask);
    wbits = q_ff.wdata & wmask & PERIPH_IMPL_MASK;
    do_write = q_ff.aw_held && q_ff.w_held && !q_ff.bvalid;
    osc_ok = q_ff.src_sel ? q_ff.xt_stable : q_ff.rc_stable;
    acc_inc = (q_ff.meas_acc == 16'hFFFF) ? q_ff.meas_acc : q_ff.meas_acc + 16'h0001;

    // Slow clock enable from the system clock
    nxt_q.slow_tick = 1'b0;
    if (q_ff.slow_div == SLOW_W'(SLOW_DIV - 1)) begin
      nxt_q.slow_div = '0;
      nxt_q.slow_tick = 1'b1;
    end else begin
      nxt_q.slow_div = q_ff.slow_div + 1'b1;
    end

    // Write channels: address and data taken in either order
    if (i_awvalid && q_ff.awready) begin
      nxt_q.aw_held = 1'b1;
      nxt_q.awaddr = i_awaddr;
    end
    if (i_wvalid && q_ff.wready) begin
      nxt_q.w_held = 1'b1;
      nxt_q.wdata = i_wdata;
      nxt_q.wstrb = i_wstrb;
    end
    if (q_ff.bvalid && i_bready) begin
      nxt_q.bvalid = 1'b0;
    end
    if (do_write) begin
      nxt_q.aw_held = 1'b0;
      nxt_q.w_held = 1'b0;
      nxt_q.bvalid = 1'b1;
      nxt_q.bresp = is_mapped(q_ff.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (q_ff.awaddr == ADDR_WRITE_PROTECT) begin
        nxt_q.wp_en = merged[WP_ENABLE_BIT];
      end else if (!q_ff.wp_en) begin
        case (q_ff.awaddr)
          ADDR_PERIPH_CLK_ENABLE: nxt_q.periph_en = q_ff.periph_en | wbits;
          ADDR_PERIPH_CLK_DISABLE: nxt_q.periph_en = q_ff.periph_en & ~wbits;
          ADDR_USB_PHY_PLL_CONFIG: begin
            nxt_q.upll_on = merged[USB_PLL_ON_BIT];
            nxt_q.upll_startup = merged[USB_PLL_STARTUP_LSB +: 4];
            nxt_q.bias_on = merged[USB_BIAS_ON_BIT];
            nxt_q.bias_startup = merged[USB_BIAS_STARTUP_LSB +: 4];
          end
          ADDR_MAIN_OSC_CONTROL: begin
            if (q_ff.wstrb[KEY_BYTE] && q_ff.wdata[KEY_LSB +: 8] == WRITE_KEY_VALUE) begin
              nxt_q.xt_on = merged[XT_ON_BIT];
              nxt_q.xt_by = merged[XT_BYPASS_BIT];
              nxt_q.rc_on = merged[RC_ON_BIT];
              nxt_q.xt_startup = merged[XT_STARTUP_LSB +: 8];
              nxt_q.src_sel = merged[SRC_SEL_BIT];
              nxt_q.cfd_on = merged[CFD_ON_BIT];
            end
          end
          ADDR_PLL_A_CONFIG: begin
            nxt_q.pll_div = merged[PLL_DIV_LSB +: 8];
            nxt_q.pll_count = merged[PLL_COUNT_LSB +: 6];
            nxt_q.pll_range = merged[PLL_RANGE_LSB +: 2];
            nxt_q.pll_mul = merged[PLL_MUL_LSB +: 8];
            nxt_q.pll_one = merged[PLL_ONE_BIT];
            pll_restart = 1'b1;
          end
          default: nxt_q.wp_en = q_ff.wp_en;
        endcase
      end
    end
    nxt_q.awready = !nxt_q.aw_held && !nxt_q.bvalid;
    nxt_q.wready = !nxt_q.w_held && !nxt_q.bvalid;

    // Read channel: one cycle from address to data
    if (q_ff.rvalid && i_rready) begin
      nxt_q.rvalid = 1'b0;
    end
    if (i_arvalid && q_ff.arready) begin
      nxt_q.rvalid = 1'b1;
      nxt_q.rdata = read_word(q_ff, i_araddr);
      nxt_q.rresp = is_mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    nxt_q.arready = !nxt_q.rvalid;

    // USB PHY bias start-up, plain slow cycles
    if (!nxt_q.bias_on || !q_ff.bias_on) begin
      nxt_q.bias_ready = 1'b0;
      nxt_q.bias_left = nxt_q.bias_startup;
    end else if (!q_ff.bias_ready) begin
      if (q_ff.bias_left == '0) begin
        nxt_q.bias_ready = 1'b1;
      end else if (q_ff.slow_tick) begin
        nxt_q.bias_left = q_ff.bias_left - 1'b1;
      end
    end

    // USB PHY PLL start-up, eight slow cycles per count
    if (!nxt_q.upll_on || !q_ff.upll_on) begin
      nxt_q.upll_locked = 1'b0;
      nxt_q.upll_left = 7'(nxt_q.upll_startup) << STARTUP_SHIFT;
    end else if (!q_ff.upll_locked) begin
      if (q_ff.upll_left == '0) begin
        nxt_q.upll_locked = 1'b1;
      end else if (q_ff.slow_tick) begin
        nxt_q.upll_left = q_ff.upll_left - 1'b1;
      end
    end

    // Crystal oscillator: bypass wins, else counted start-up
    if (nxt_q.xt_by) begin
      nxt_q.xt_stable = 1'b1;
    end else if (!nxt_q.xt_on || !q_ff.xt_on) begin
      nxt_q.xt_stable = 1'b0;
      nxt_q.xt_left = 11'(nxt_q.xt_startup) << STARTUP_SHIFT;
    end else if (!q_ff.xt_stable) begin
      if (q_ff.xt_left == '0) begin
        nxt_q.xt_stable = 1'b1;
      end else if (q_ff.slow_tick) begin
        nxt_q.xt_left = q_ff.xt_left - 1'b1;
      end
    end

    // RC oscillator start-up
    if (!nxt_q.rc_on) begin
      nxt_q.rc_stable = 1'b0;
      nxt_q.rc_left = 8'(RC_STARTUP);
    end else if (!q_ff.rc_stable) begin
      if (q_ff.rc_left == '0) begin
        nxt_q.rc_stable = 1'b1;
      end else if (q_ff.slow_tick) begin
        nxt_q.rc_left = q_ff.rc_left - 1'b1;
      end
    end

    // PLL A lock counter, restarted by every unprotected PLL A config write
    if (pll_restart) begin
      nxt_q.pll_locked = 1'b0;
      nxt_q.pll_left = nxt_q.pll_count;
    end else if (q_ff.pll_mul == '0) begin
      nxt_q.pll_locked = 1'b0;
    end else if (!q_ff.pll_locked) begin
      if (q_ff.pll_left == '0) begin
        nxt_q.pll_locked = 1'b1;
      end else if (q_ff.slow_tick) begin
        nxt_q.pll_left = q_ff.pll_left - 1'b1;
      end
    end

    // Main clock frequency meter over sixteen slow periods
    case (q_ff.meas_state)
      MEAS_IDLE: begin
        nxt_q.measured_main_count_rdy = 1'b0;
        if (osc_ok && q_ff.slow_tick) begin
          nxt_q.meas_state = MEAS_RUN;
          nxt_q.meas_win = MEASURE_PERIODS;
          nxt_q.meas_acc = '0;
        end
      end
      MEAS_RUN: begin
        if (!osc_ok) begin
          nxt_q.meas_state = MEAS_IDLE;
          nxt_q.measured_main_count_rdy = 1'b0;
        end else begin
          if (i_main_clk_tick) begin
            nxt_q.meas_acc = acc_inc;
          end
          if (q_ff.slow_tick) begin
            if (q_ff.meas_win == 5'h01) begin
              nxt_q.measured_main_count = i_main_clk_tick ? acc_inc : q_ff.meas_acc;
              nxt_q.measured_main_count_rdy = 1'b1;
              nxt_q.meas_win = MEASURE_PERIODS;
              nxt_q.meas_acc = '0;
            end else begin
              nxt_q.meas_win = q_ff.meas_win - 1'b1;
            end
          end
        end
      end
      default: nxt_q.meas_state = MEAS_IDLE;
    endcase

    // Synchronous reset values
    if (i_reset) begin
      nxt_q = '0;
      nxt_q.meas_state = MEAS_IDLE;
      nxt_q.awready = 1'b1;
      nxt_q.wready = 1'b1;
      nxt_q.arready = 1'b1;
      nxt_q.upll_on = USB_PHY_RESET[USB_PLL_ON_BIT];
      nxt_q.upll_startup = USB_PHY_RESET[USB_PLL_STARTUP_LSB +: 4];
      nxt_q.bias_on = USB_PHY_RESET[USB_BIAS_ON_BIT];
      nxt_q.bias_startup = USB_PHY_RESET[USB_BIAS_STARTUP_LSB +: 4];
      nxt_q.xt_on = MAIN_OSC_RESET[XT_ON_BIT];
      nxt_q.xt_by = MAIN_OSC_RESET[XT_BYPASS_BIT];
      nxt_q.rc_on = MAIN_OSC_RESET[RC_ON_BIT];
      nxt_q.xt_startup = MAIN_OSC_RESET[XT_STARTUP_LSB +: 8];
      nxt_q.pll_div = PLL_A_RESET[PLL_DIV_LSB +: 8];
      nxt_q.pll_count = PLL_A_RESET[PLL_COUNT_LSB +: 6];
      nxt_q.pll_mul = PLL_A_RESET[PLL_MUL_LSB +: 8];
      nxt_q.rc_left = 8'(RC_STARTUP);
    end
  end

  always_ff @(posedge i_clk) begin
    q_ff <= nxt_q;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_awready = q_ff.awready;
  assign o_wready = q_ff.wready;
  assign o_bvalid = q_ff.bvalid;
  assign o_bresp = q_ff.bresp;
  assign o_arready = q_ff.arready;
  assign o_rvalid = q_ff.rvalid;
  assign o_rdata = q_ff.rdata;
  assign o_rresp = q_ff.rresp;
  assign o_peripheral_clock_bit = q_ff.periph_en;
  assign o_usb_phy_pll_on = q_ff.upll_on;
  assign o_usb_phy_pll_locked = q_ff.upll_locked;
  assign o_usb_phy_bias_on = q_ff.bias_on;
  assign o_usb_phy_bias_ready = q_ff.bias_ready;
  assign o_crystal_osc_on = q_ff.xt_on;
  assign o_crystal_osc_bypass = q_ff.xt_by;
  assign o_crystal_osc_stable = q_ff.xt_stable;
  assign o_rc_osc_on = q_ff.rc_on;
  assign o_rc_osc_stable = q_ff.rc_stable;
  assign o_main_source_select = q_ff.src_sel;
  assign o_clock_fail_detect_on = q_ff.cfd_on;
  assign o_pll_a_divider = q_ff.pll_div;
  assign o_pll_a_multiplier = q_ff.pll_mul;
  assign o_pll_a_freq_range = q_ff.pll_range;
  assign o_pll_a_locked = q_ff.pll_locked;

endmodule

`default_nettype wire

// *** dv/clock_gen_assertions.sv ***
// Port checker for the clock generator control block
`timescale 1ns/1ps
`default_nettype none
module clock_gen_chk (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Bus handshake
  input wire logic i_bready,
  input wire logic i_rready,
  input wire logic o_awready,
  input wire logic o_bvalid,
  input wire logic [1:0] o_bresp,
  input wire logic o_rvalid,
  input wire logic [1:0] o_rresp,
  // Clock controls
  input wire logic [31:0] o_peripheral_clock_bit,
  input wire logic o_usb_phy_pll_on,
  input wire logic o_usb_phy_pll_locked,
  input wire logic o_crystal_osc_on,
  input wire logic o_crystal_osc_bypass,
  input wire logic o_crystal_osc_stable,
  input wire logic [7:0] o_pll_a_multiplier,
  input wire logic o_pll_a_locked
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_b_wait;
    o_bvalid && !i_bready;
  endsequence
  sequence s_xt_off;
    (!o_crystal_osc_on && !o_crystal_osc_bypass) [*2];
  endsequence
  chk_bresp_hold:
    assert property (s_b_wait |=> o_bvalid && $stable(o_bresp)) else $error("bresp dropped");
  chk_rresp_hold:
    assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rresp))
    else $error("rresp dropped");
  chk_aw_blocked:
    assert property (o_bvalid |-> !o_awready) else $error("address taken in response");
  chk_pid_low:
    assert property (o_peripheral_clock_bit[1:0] == 2'h0) else $error("bad clock bit on");
  chk_upll_off:
    assert property ((!o_usb_phy_pll_on) [*2] |-> !o_usb_phy_pll_locked)
    else $error("usb pll locked while off");
  chk_byp_fast:
    assert property ($rose(o_crystal_osc_bypass) |-> ##[0:2] o_crystal_osc_stable)
    else $error("bypass not stable");
  chk_xt_cleared:
    assert property (s_xt_off |-> !o_crystal_osc_stable) else $error("crystal stable while off");
  chk_mul_off:
    assert property ((o_pll_a_multiplier == 8'h00) [*2] |-> !o_pll_a_locked)
    else $error("pll a locked while off");
  chk_lock_restart:
    assert property ($changed(o_pll_a_multiplier) |-> !o_pll_a_locked)
    else $error("pll a lock kept over write");
endmodule
bind clock_gen_osc_pll_control clock_gen_chk u_clock_gen_chk (
  .i_clk, .i_reset, .i_bready, .i_rready, .o_awready, .o_bvalid, .o_bresp, .o_rvalid, .o_rresp,
  .o_peripheral_clock_bit, .o_usb_phy_pll_on, .o_usb_phy_pll_locked, .o_crystal_osc_on,
  .o_crystal_osc_bypass, .o_crystal_osc_stable, .o_pll_a_multiplier, .o_pll_a_locked);
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the clock generator control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import clock_gen_pkg::*;
  localparam int SD = 4;
  logic i_clk = 0, i_reset = 1, i_main_clk_tick = 0;
  logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic [31:0] i_awaddr = 0, i_wdata = 0, i_araddr = 0, rdv, m, v;
  logic [3:0] i_wstrb = 4'hF;
  logic [1:0] rsp, o_bresp, o_rresp;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_rc_osc_stable;
  logic o_usb_phy_pll_locked, o_usb_phy_bias_ready, o_crystal_osc_stable, o_pll_a_locked;
  logic o_rc_osc_on, o_main_source_select, o_clock_fail_detect_on, o_usb_phy_bias_on;
  logic [31:0] o_rdata, o_peripheral_clock_bit;
  logic [7:0] o_pll_a_divider, o_pll_a_multiplier;
  int n_fail = 0, total_checks = 0, cyc = 0, t0, c;
  wire logic [3:0] flg = {o_pll_a_locked, o_crystal_osc_stable, o_usb_phy_bias_ready,
    o_usb_phy_pll_locked};

  clock_gen_osc_pll_control #(.SLOW_DIV(SD), .RC_STARTUP(2)) u_clock_gen_osc_pll_control (
    .i_clk, .i_reset, .i_main_clk_tick, .i_awvalid, .o_awready, .i_awaddr, .i_awprot(3'h0),
    .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid,
    .o_arready, .i_araddr, .i_arprot(3'h0), .o_rvalid, .i_rready, .o_rdata, .o_rresp,
    .o_peripheral_clock_bit, .o_usb_phy_pll_on(), .o_usb_phy_pll_locked, .o_usb_phy_bias_on,
    .o_usb_phy_bias_ready, .o_crystal_osc_on(), .o_crystal_osc_bypass(), .o_crystal_osc_stable,
    .o_rc_osc_on, .o_rc_osc_stable, .o_main_source_select, .o_clock_fail_detect_on,
    .o_pll_a_divider, .o_pll_a_multiplier, .o_pll_a_freq_range(), .o_pll_a_locked);

  always #12.5 i_clk = ~i_clk;
  // Main clock marker on every other cycle
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    i_main_clk_tick <= cyc[0];
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  function automatic logic [31:0] pw(logic [7:0] dv, logic [5:0] cn, logic [7:0] ml);
    return 32'h2000_0000 | {8'h00, ml, 2'h0, cn, dv};
  endfunction

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    int n, st;
    st = $urandom % 3;
    i_awvalid <= 1;
    i_awaddr <= a;
    i_wvalid <= 1;
    i_wdata <= d;
    i_wstrb <= s;
    for (n = 1; n < 40; n++) begin
      @(posedge i_clk);
      if (o_bvalid && i_bready) break;
      if (o_awready) i_awvalid <= 0;
      if (o_wready) i_wvalid <= 0;
      if (n >= st) i_bready <= 1;
    end
    i_bready <= 0;
    rsp = o_bresp;
    if (n == 40) chk("write_wait", 0, 1);
    if (n == 40) finish_test;
  endtask

  task automatic rd(input logic [31:0] a);
    int n, st;
    st = $urandom % 3;
    i_arvalid <= 1;
    i_araddr <= a;
    for (n = 1; n < 40; n++) begin
      @(posedge i_clk);
      if (o_rvalid && i_rready) break;
      if (o_arready) i_arvalid <= 0;
      if (n >= st) i_rready <= 1;
    end
    i_rready <= 0;
    rdv = o_rdata;
    rsp = o_rresp;
    if (n == 40) chk("read_wait", 0, 1);
    if (n == 40) finish_test;
  endtask

  task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, rdv, e);
  endtask

  // Flag must rise between k-1 slow ticks and k+1 slow ticks plus four cycles after t
  task automatic wt(input int b, input int t, input int k);
    while (!flg[b] && cyc - t <= (k + 1) * SD + 4) @(posedge i_clk);
    chk("flag_time", (cyc - t >= (k - 1) * SD) && flg[b], 1);
    if (!flg[b]) finish_test;
  endtask

  initial begin
    m = $urandom(32'hAE0A);
    repeat (6) @(posedge i_clk);
    i_reset <= 0;
    @(posedge i_clk);
    chk("rc_early", o_rc_osc_stable, 0);
    rc("usb_rst", ADDR_USB_PHY_PLL_CONFIG, USB_PHY_RESET);
    rc("pll_rst", ADDR_PLL_A_CONFIG, PLL_A_RESET);
    m = 0;
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      wr(ADDR_PERIPH_CLK_ENABLE, v);
      m = m | (v & PERIPH_IMPL_MASK);
      v = (i == 3) ? 32'hFFFF_FFFF : $urandom;
      wr(ADDR_PERIPH_CLK_DISABLE, v);
      m = m & ~v;
      rc("pcsr", ADDR_PERIPH_CLK_STATUS, m);
      chk("pclk", o_peripheral_clock_bit, m);
    end
    wr(ADDR_PERIPH_CLK_ENABLE, 32'hFFFF_FFFF);
    wr(ADDR_WRITE_PROTECT, 32'h1);
    wr(ADDR_PERIPH_CLK_DISABLE, 32'h0000_00F0);
    wr(ADDR_PLL_A_CONFIG, pw(8'h05, 6'h01, 8'h07));
    rc("wp_pcsr", ADDR_PERIPH_CLK_STATUS, PERIPH_IMPL_MASK);
    rc("wp_pll", ADDR_PLL_A_CONFIG, PLL_A_RESET);
    wr(ADDR_WRITE_PROTECT, 32'h0);
    wr(32'h0FFF_FC2C, 32'h1234_5678);
    chk("unm_wr", rsp, RESP_SLVERR);
    rc("unm_rd", 32'h0FFF_FC2C, 32'h0);
    chk("unm_rsp", rsp, RESP_SLVERR);
    // Oscillator writes: bad key, key outside strobes, then good key
    wr(ADDR_MAIN_OSC_CONTROL, 32'h0300_0109 | (32'($urandom % 55) << 16));
    wr(ADDR_MAIN_OSC_CONTROL, 32'h0337_0109, 4'hB);
    rc("key", ADDR_MAIN_OSC_CONTROL, MAIN_OSC_RESET);
    chk("sel0", o_main_source_select, 0);
    chk("rc_on", o_rc_osc_on, 1);
    rd(ADDR_CLOCK_STATUS);
    chk("xt_pre", rdv[0], 0);
    wr(ADDR_MAIN_OSC_CONTROL, 32'h0337_0109);
    t0 = cyc;
    chk("sel1", o_main_source_select, 1);
    chk("cfd", o_clock_fail_detect_on, 1);
    wt(2, t0, 8);
    rc("osc_rd", ADDR_MAIN_OSC_CONTROL, 32'h0300_0109);
    wr(ADDR_MAIN_OSC_CONTROL, 32'h0037_0008);
    repeat (2) @(posedge i_clk);
    chk("xt_off", o_crystal_osc_stable, 0);
    chk("cfd_off", o_clock_fail_detect_on, 0);
    wr(ADDR_MAIN_OSC_CONTROL, 32'h0037_000A);
    @(posedge i_clk);
    rd(ADDR_CLOCK_STATUS);
    chk("xt_byp", rdv[0], 1);
    chk("rc_st", rdv[17], 1);
    c = 1 + $urandom % 3;
    wr(ADDR_USB_PHY_PLL_CONFIG, 32'h3101_0000 | (32'(c) << 20));
    t0 = cyc;
    wt(1, t0, 3);
    chk("bias_on", o_usb_phy_bias_on, 1);
    wt(0, t0, 8 * c);
    for (int i = 0; i < 3; i++) begin
      if (i != 1) v = pw(8'(2 + $urandom % 254), 6'(1 + $urandom % 3), 8'(1 + $urandom % 254));
      wr(ADDR_PLL_A_CONFIG, v);
      t0 = cyc;
      chk("lk_clr", o_pll_a_locked, 0);
      chk("pll_a_divider", o_pll_a_divider, v[7:0]);
      chk("pll_a_multiplier", o_pll_a_multiplier, v[23:16]);
      rc("pll_rd", ADDR_PLL_A_CONFIG, v);
      wt(3, t0, v[13:8]);
    end
    wr(ADDR_PLL_A_CONFIG, pw(8'h01, 6'h01, 8'h00));
    repeat (3 * SD) @(posedge i_clk);
    chk("mul0", o_pll_a_locked, 0);
    rdv = 0;
    for (int i = 0; i < 100 && rdv[16] !== 1'b1; i++) rd(ADDR_MAIN_CLK_FREQ);
    rd(ADDR_MAIN_CLK_FREQ);
    chk("mrdy", rdv[16], 1);
    chk("measured_main_count", rdv[15:0] >= 31 && rdv[15:0] <= 33, 1);
    finish_test;
  end
endmodule
`default_nettype wire
